// [common/ypk_pkg.sv]
// shared constants and types for the yuv 4:2:2 pixel packer
package ypk_pkg;
  localparam int RAW_W = 8;
  localparam int COL_W = 11;
  localparam int LINE_MAX = 2048;
  // fixed-point colour weights scaled by 256
  localparam logic signed [9:0] Y_R = 10'sd77;
  localparam logic signed [9:0] Y_G = 10'sd151;
  localparam logic signed [9:0] Y_B = 10'sd28;
  localparam logic signed [9:0] U_R = -10'sd44;
  localparam logic signed [9:0] U_G = -10'sd84;
  localparam logic signed [9:0] U_B = 10'sd128;
  localparam logic signed [9:0] V_R = 10'sd128;
  localparam logic signed [9:0] V_G = -10'sd105;
  localparam logic signed [9:0] V_B = -10'sd23;
  localparam int FRAC_W = 8;
  localparam logic signed [19:0] ROUND_HALF = 20'sh00080;
  localparam logic signed [19:0] LUMA_MAX = 20'sh000ff;
  localparam logic signed [19:0] CHROMA_MAX = 20'sh0007f;
  localparam logic signed [19:0] CHROMA_MIN = -20'sh00080;
  localparam logic [7:0] CHROMA_OFFSET = 8'h80;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  // colour site of a sample given {row parity, column parity}
  localparam logic [1:0] SITE_BLUE = 2'h0;
  localparam logic [1:0] SITE_GREEN_B = 2'h1;
  localparam logic [1:0] SITE_GREEN_R = 2'h2;
  localparam logic [1:0] SITE_RED = 2'h3;

  typedef enum logic {ORDER_UYVY, ORDER_YUYV} ypk_order_t;

  // one raw sensor sample, with a second capture for averaging
  typedef struct packed {
    logic sof;
    logic sol;
    logic [RAW_W-1:0] samp_a;
    logic [RAW_W-1:0] samp_b;
  } ypk_raw_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } ypk_rgb_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } ypk_yuv_t;
endpackage

// [design/ypk_packer.sv]
// raw bayer samples to packed yuv 4:2:2 byte stream
// Function
// - rebuild full rgb per pixel from neighbouring single-colour samples
// - luma is 0.30 red plus 0.59 green plus 0.11 blue
// - blue chroma is -0.17 red, -0.33 green, +0.50 blue
// - red chroma is 0.50 red, -0.41 green, -0.09 blue
// - both chroma values get 128 added to become unsigned bytes
// - uyvy order sends u0, y0, v0, y1 per pixel pair
// - yuyv order sends y0, u0, y1, v0 per pixel pair
// - luma for both pixels of a pair, chroma once per pair from even pixel
// - luma byte is plain unsigned, 0x00 to 0xff linear
// - chroma byte is offset binary, 0x80 means zero
// - with averaging on, the averaged samples feed interpolation and conversion
// - both orders carry identical values, only byte sequence differs
`timescale 1ns/1ps
module ypk_packer (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_avg_en,
  input wire logic i_order_yuyv,
  input wire ypk_pkg::ypk_raw_t i_raw,
  input wire logic i_raw_valid,
  output logic o_raw_ready,
  output logic [7:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  typedef enum logic {ST_IDLE, ST_SEND} ypk_state_t;

  // multiply-accumulate with rounding, result in whole levels
  function automatic logic signed [19:0] mac(input logic signed [9:0] cr, input logic signed [9:0] cg,
                                             input logic signed [9:0] cb, input ypk_pkg::ypk_rgb_t px);
    logic signed [19:0] acc;
    // widen both factors first so no tool can evaluate the product at ten bits
    acc = 20'(cr) * $signed({12'h000, px.r}) + 20'(cg) * $signed({12'h000, px.g})
        + 20'(cb) * $signed({12'h000, px.b}) + ypk_pkg::ROUND_HALF;
    mac = acc >>> ypk_pkg::FRAC_W;
  endfunction

  // byte selection for each position of a pair
  function automatic logic [7:0] pick(input logic yuyv, input logic [1:0] idx, input logic [7:0] y0,
                                      input logic [7:0] u, input logic [7:0] v, input logic [7:0] y1);
    case ({yuyv, idx})
      3'h0: pick = u;
      3'h1: pick = y0;
      3'h2: pick = v;
      3'h3: pick = y1;
      3'h4: pick = y0;
      3'h5: pick = u;
      3'h6: pick = y1;
      default: pick = v;
    endcase
  endfunction

  logic [7:0] line_mem [ypk_pkg::LINE_MAX];
  logic [ypk_pkg::COL_W-1:0] col;
  logic row_odd;
  logic [7:0] left;
  logic [7:0] above_left;
  ypk_pkg::ypk_rgb_t rgb;
  logic rgb_valid;
  logic rgb_odd;
  ypk_state_t state;
  logic [1:0] byte_idx;
  logic [7:0] y0_hold;
  logic [7:0] u_hold;
  logic [7:0] v_hold;
  logic [7:0] y1_hold;
  logic order_hold;

  // input position; a start-of-line sample is column zero
  wire take_in = i_raw_valid && o_raw_ready;
  wire [ypk_pkg::COL_W-1:0] cur_col = i_raw.sol ? '0 : col;
  wire cur_row_odd = i_raw.sof ? 1'b0 : (i_raw.sol ? ~row_odd : row_odd);
  wire [8:0] avg_sum = {1'b0, i_raw.samp_a} + {1'b0, i_raw.samp_b} + 9'h001;
  wire [7:0] samp = i_avg_en ? avg_sum[8:1] : i_raw.samp_a;
  wire [7:0] above = line_mem[cur_col];
  wire [7:0] win_left = i_raw.sol ? 8'h00 : left;
  wire [7:0] win_al = i_raw.sol ? 8'h00 : above_left;
  wire [1:0] site = {cur_row_odd, cur_col[0]};

  // 2x2 window interpolation; column zero sees zero left neighbours, while the
  // first row reads whatever the line buffer still holds, so its pixels are not exact
  wire [8:0] g_diag = {1'b0, samp} + {1'b0, win_al} + 9'h001;
  wire [8:0] g_cross = {1'b0, above} + {1'b0, win_left} + 9'h001;
  ypk_pkg::ypk_rgb_t next_rgb;
  always_comb begin
    next_rgb = '0;
    case (site)
      ypk_pkg::SITE_RED: begin
        next_rgb = '{r: samp, g: g_cross[8:1], b: win_al};
      end
      ypk_pkg::SITE_BLUE: begin
        next_rgb = '{r: win_al, g: g_cross[8:1], b: samp};
      end
      ypk_pkg::SITE_GREEN_B: begin
        next_rgb = '{r: above, g: g_diag[8:1], b: win_left};
      end
      default: begin
        next_rgb = '{r: win_left, g: g_diag[8:1], b: above};
      end
    endcase
  end

  // colour conversion from the registered rgb pixel
  wire signed [19:0] y_full = mac(ypk_pkg::Y_R, ypk_pkg::Y_G, ypk_pkg::Y_B, rgb);
  wire signed [19:0] u_full = mac(ypk_pkg::U_R, ypk_pkg::U_G, ypk_pkg::U_B, rgb);
  wire signed [19:0] v_full = mac(ypk_pkg::V_R, ypk_pkg::V_G, ypk_pkg::V_B, rgb);
  // clamp before truncation so that bright saturated colours cannot wrap
  wire signed [19:0] y_sat = y_full < 0 ? 20'sh0 : (y_full > ypk_pkg::LUMA_MAX ? ypk_pkg::LUMA_MAX : y_full);
  wire signed [19:0] u_sat = u_full < ypk_pkg::CHROMA_MIN ? ypk_pkg::CHROMA_MIN
                           : (u_full > ypk_pkg::CHROMA_MAX ? ypk_pkg::CHROMA_MAX : u_full);
  wire signed [19:0] v_sat = v_full < ypk_pkg::CHROMA_MIN ? ypk_pkg::CHROMA_MIN
                           : (v_full > ypk_pkg::CHROMA_MAX ? ypk_pkg::CHROMA_MAX : v_full);
  ypk_pkg::ypk_yuv_t yuv;
  assign yuv.y = y_sat[7:0];
  assign yuv.u = u_sat[7:0] + ypk_pkg::CHROMA_OFFSET;
  assign yuv.v = v_sat[7:0] + ypk_pkg::CHROMA_OFFSET;

  // handshakes: the converted pixel waits while a pair is being sent
  wire sending = state == ST_SEND;
  wire take_pix = rgb_valid && !sending;
  wire pair_start = take_pix && rgb_odd;
  wire out_fire = sending && i_ready;
  wire pair_done = out_fire && byte_idx == ypk_pkg::LAST_BYTE;
  assign o_raw_ready = !rgb_valid || take_pix;
  assign o_valid = sending;

  // line buffer of the previous row
  always_ff @(posedge i_clk_sys) begin
    if (take_in) begin
      line_mem[cur_col] <= samp;
    end
  end

  // position tracking and window registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      col <= '0;
      row_odd <= 1'b0;
      left <= 8'h00;
      above_left <= 8'h00;
    end else if (take_in) begin
      col <= cur_col + 1'b1;
      row_odd <= cur_row_odd;
      left <= samp;
      above_left <= above;
    end
  end

  // rgb stage
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rgb <= '0;
      rgb_valid <= 1'b0;
      rgb_odd <= 1'b0;
    end else if (o_raw_ready) begin
      rgb <= next_rgb;
      rgb_valid <= i_raw_valid;
      rgb_odd <= cur_col[0];
    end
  end

  // chroma comes only from the even pixel; a lone even pixel at line end is dropped
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      y0_hold <= 8'h00;
      u_hold <= 8'h00;
      v_hold <= 8'h00;
      y1_hold <= 8'h00;
      order_hold <= 1'b0;
    end else if (take_pix && !rgb_odd) begin
      y0_hold <= yuv.y;
      u_hold <= yuv.u;
      v_hold <= yuv.v;
    end else if (pair_start) begin
      y1_hold <= yuv.y;
      order_hold <= i_order_yuyv;
    end
  end

  // pair serialiser
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      byte_idx <= 2'h0;
      o_data <= 8'h00;
    end else if (pair_start) begin
      state <= ST_SEND;
      byte_idx <= 2'h0;
      o_data <= pick(i_order_yuyv, 2'h0, y0_hold, u_hold, v_hold, yuv.y);
    end else if (pair_done) begin
      state <= ST_IDLE;
    end else if (out_fire) begin
      byte_idx <= byte_idx + 2'h1;
      o_data <= pick(order_hold, byte_idx + 2'h1, y0_hold, u_hold, v_hold, y1_hold);
    end
  end

  a_gray_luma: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    rgb_valid && rgb.r == rgb.g && rgb.g == rgb.b |-> yuv.y == rgb.r)
    else $error("gray pixel luma differs from its level");
  a_gray_u_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    rgb_valid && rgb.r == rgb.g && rgb.g == rgb.b |-> yuv.u == 8'h80)
    else $error("gray pixel blue chroma not at midpoint");
  a_gray_v_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    rgb_valid && rgb.r == rgb.g && rgb.g == rgb.b |-> yuv.v == 8'h80)
    else $error("gray pixel red chroma not at midpoint");
  a_red_v_sat: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    rgb.r == 8'hff && rgb.g == 8'h00 && rgb.b == 8'h00 |-> yuv.v == 8'hff && yuv.u == 8'h54)
    else $error("full red did not saturate chroma correctly");
  a_red_site_pass: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    take_in && site == ypk_pkg::SITE_RED |=> rgb.r == $past(samp))
    else $error("red site sample not carried into red component");
  a_avg_used: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    take_in && i_avg_en && site == ypk_pkg::SITE_BLUE
    |=> 9'(rgb.b) == 9'(($past(i_raw.samp_a) + 9'($past(i_raw.samp_b)) + 9'h001) >> 1))
    else $error("averaged sample not used for interpolation");
  a_uyvy_first: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    pair_start && !i_order_yuyv |=> o_valid && o_data == u_hold ##0 (o_data == u_hold) [*1])
    else $error("uyvy pair does not open with blue chroma");
  a_yuyv_third: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sending && order_hold && out_fire && byte_idx == 2'h1 |=> o_data == y1_hold)
    else $error("yuyv third byte is not odd pixel luma");
  a_pair_four: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    pair_start ##1 (i_ready && o_valid) [*4] |=> !o_valid)
    else $error("pair did not end after four bytes");
endmodule

// [bench/ypk_host_sink.sv]
// host buffer model: takes packed bytes, can stall the stream
`timescale 1ns/1ps
module ypk_host_sink (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  input wire logic i_stall_en,
  output logic o_ready
);
  logic [7:0] q[$];
  int cnt;
  // ready changes at the falling edge only; stalls every third cycle to stress the hold
  initial begin
    o_ready = 1'b1;
    cnt = 0;
    forever begin
      @(negedge i_clk_sys);
      cnt = cnt + 1;
      o_ready <= !(i_stall_en && (cnt % 3 == 0));
    end
  end
  // a byte counts as taken on a rising edge with valid and ready both high
  always @(posedge i_clk_sys) begin
    if (i_reset_n && i_valid === 1'b1 && o_ready) begin
      q.push_back(i_data);
    end
  end
endmodule

// [bench/ypk_packer_tb.sv]
// self-checking bench for the yuv 4:2:2 pixel packer
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ypk_packer_tb;
  logic i_clk_sys, i_reset_n, i_avg_en, i_order_yuyv, i_raw_valid, o_raw_ready, o_valid, i_ready, stall_en;
  ypk_pkg::ypk_raw_t i_raw;
  logic [7:0] o_data;
  int n_errors = 0;
  int num_checks = 0;
  ypk_packer ypk_packer_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_avg_en(i_avg_en),
    .i_order_yuyv(i_order_yuyv), .i_raw(i_raw), .i_raw_valid(i_raw_valid), .o_raw_ready(o_raw_ready),
    .o_data(o_data), .o_valid(o_valid), .i_ready(i_ready));
  ypk_host_sink ypk_host_sink_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_data(o_data),
    .i_valid(o_valid), .i_stall_en(stall_en), .o_ready(i_ready));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // own fixed-point conversion: weights from the package, round, saturate, offset chroma
  function automatic logic [7:0] cv(int r, int g, int b, int wr, int wg, int wb, bit chroma);
    int s;
    s = (wr * r + wg * g + wb * b + 128) >>> 8;
    if (chroma) begin
      s = (s > 127) ? 127 : ((s < -128) ? -128 : s);
      return 8'(s + 128);
    end
    s = (s > 255) ? 255 : ((s < 0) ? 0 : s);
    return 8'(s);
  endfunction
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one sample offered at the falling edge, held until an edge that sees ready
  task automatic send(logic sof, logic sol, logic [7:0] a, logic [7:0] b);
    logic rdy;
    @(negedge i_clk_sys);
    i_raw = '{sof: sof, sol: sol, samp_a: a, samp_b: b};
    i_raw_valid = 1'b1;
    for (int t = 0; t < 50; t++) begin
      #1 rdy = o_raw_ready;
      @(posedge i_clk_sys);
      if (rdy === 1'b1) begin
        return;
      end
      @(negedge i_clk_sys);
    end
    n_errors++;
    end_of_test();
  endtask
  // two rows of nine samples, site colours uniform, so every inner pixel of the second row has the same rgb
  task automatic run_frame(bit yuyv, bit avg, bit stall, logic [7:0] ra, rb, ga, gb, ba, bb);
    int r, g, b;
    logic [7:0] y, u, v;
    logic [7:0] e[4];
    r = avg ? (ra + rb + 1) >> 1 : ra;
    g = avg ? (ga + gb + 1) >> 1 : ga;
    b = avg ? (ba + bb + 1) >> 1 : ba;
    y = cv(r, g, b, ypk_pkg::Y_R, ypk_pkg::Y_G, ypk_pkg::Y_B, 1'b0);
    u = cv(r, g, b, ypk_pkg::U_R, ypk_pkg::U_G, ypk_pkg::U_B, 1'b1);
    v = cv(r, g, b, ypk_pkg::V_R, ypk_pkg::V_G, ypk_pkg::V_B, 1'b1);
    if (yuyv) begin
      e = '{y, u, y, v};
    end else begin
      e = '{u, y, v, y};
    end
    @(negedge i_clk_sys);
    ypk_host_sink_i.q.delete();
    i_order_yuyv = yuyv;
    i_avg_en = avg;
    stall_en = stall;
    for (int row = 0; row < 2; row++) begin
      for (int col = 0; col < 9; col++) begin
        case ({row[0], col[0]})
          2'h0: send(row == 0 && col == 0, col == 0, ba, bb);
          2'h3: send(1'b0, col == 0, ra, rb);
          default: send(row == 0 && col == 0, col == 0, ga, gb);
        endcase
      end
    end
    @(negedge i_clk_sys);
    i_raw_valid = 1'b0;
    for (int t = 0; t < 400 && ypk_host_sink_i.q.size() < 32; t++) begin
      @(negedge i_clk_sys);
    end
    repeat (4) @(negedge i_clk_sys);
    `CHK(ypk_host_sink_i.q.size(), 32)
    if (ypk_host_sink_i.q.size() != 32) begin
      end_of_test();
    end
    for (int k = 5; k < 8; k++) begin
      for (int j = 0; j < 4; j++) begin
        `CHK(ypk_host_sink_i.q[4 * k + j], e[j])
      end
    end
  endtask
  // reset state: idle output, input ready
  task automatic sc_reset();
    `CHK(o_valid, 1'b0)
    `CHK(o_raw_ready, 1'b1)
  endtask
  // full white in camera order: top luma code, chroma at offset zero
  task automatic sc_white_uyvy();
    run_frame(1'b0, 1'b0, 1'b0, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00);
  endtask
  // pure red in yuyv order under stalls: red chroma saturates instead of wrapping
  task automatic sc_red_yuyv_stall();
    run_frame(1'b1, 1'b0, 1'b1, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
  endtask
  // same red in camera order: identical values, other sequence
  task automatic sc_red_uyvy();
    run_frame(1'b0, 1'b0, 1'b0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
  endtask
  // averaging on then off: second capture changes the result only when on, odd sums round up
  task automatic sc_average();
    run_frame(1'b1, 1'b1, 1'b1, 8'h10, 8'h31, 8'hc8, 8'h65, 8'h64, 8'hc9);
    run_frame(1'b0, 1'b0, 1'b0, 8'h00, 8'hff, 8'hff, 8'h11, 8'h20, 8'hff);
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_avg_en = 1'b0;
    i_order_yuyv = 1'b0;
    i_raw = '0;
    i_raw_valid = 1'b0;
    stall_en = 1'b0;
    repeat (20) @(negedge i_clk_sys);
    sc_reset();
    i_reset_n = 1'b1;
    sc_white_uyvy();
    sc_red_yuyv_stall();
    sc_red_uyvy();
    sc_average();
    end_of_test();
  end
endmodule
